// [sdc_top.sv]
// Soft-strap loader presetting EEE and port 0 speed defaults, APB slave
`timescale 1ns/100ps
module sdc_top (
  input wire logic sys_clk, // System clock, 250 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic eee_select_pin, // EEE strap pin
  input wire logic port0_rate_indicator_pin, // Port 0 speed indicator pin
  input wire logic phy_b_fx_mode, // PHY B in 100BASE-FX, pin level
  input wire logic port0_rmii_mac, // Port 0 in RMII MAC mode, pin level
  input wire logic ee_done, // EEPROM loader finished
  input wire logic ee_valid, // EEPROM contents present
  input wire logic ee_eee_bit, // EEPROM EEE strap bit
  input wire logic ee_port0_bit, // EEPROM shared port 0 bit
  input wire logic vphy_an_failed, // Virtual negotiation failed
  input wire logic vphy_an_spd100, // Negotiated speed is 100
  output logic mac_tx_eee_on, // MAC Mac_tx_eee_on
  output logic phy_eee_on, // PHY B Mac_tx_eee_on
  output logic port0_spd100, // Port 0 resolved speed 100
  output logic cfg_ready // Defaults applied, access open
);
  logic [sdc_pkg::SYNC_W-1:0] pins_s; // Synchronised pins
  logic eee_pin_s, rate_pin_s, fx_s, rmii_s; // Split pin levels
  sdc_pkg::sdc_state_t state_q; // Load sequence state
  logic [1:0] settle_q; // Settle counter
  sdc_pkg::sdc_straps_t straps_q; // Strap register
  logic ee_used_q; // EEPROM took over
  logic mac_eee_q; // MAC Mac_tx_eee_on bit
  logic [2:0] phy_eee_q; // PHY EEE bits
  logic [3:0] lp_q; // Partner ability bits
  logic spd_q; // Resolved port 0 speed
  logic [31:0] rdata_q; // Read data register
  logic ready_q; // Access phase answer
  logic err_q; // Error answer
  logic access; // Access phase in progress
  logic wr_en; // Write takes effect this edge
  logic pin_100; // Decoded rate pin
  logic rdy_q; // Defaults applied, mirrors the ready state

  // Address mapped check, used for writes and reads
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == sdc_pkg::ADDR_STRAP) || (a == sdc_pkg::ADDR_MAC_TX) ||
               (a == sdc_pkg::ADDR_PHY_EEE) || (a == sdc_pkg::ADDR_VPHY_LP) ||
               (a == sdc_pkg::ADDR_STATUS);
  endfunction

  // Partner ability pattern from the shared speed bit
  function automatic logic [3:0] lp_from_speed(input logic s);
    logic [3:0] v;
    v = 4'h0;
    v[sdc_pkg::LP_100FD_BIT] = s;
    v[sdc_pkg::LP_100HD_BIT] = s;
    v[sdc_pkg::LP_10FD_BIT] = ~s;
    v[sdc_pkg::LP_10HD_BIT] = ~s;
    lp_from_speed = v;
  endfunction

  // Pins are asynchronous to sys_clk
  sdc_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in({eee_select_pin, port0_rate_indicator_pin, phy_b_fx_mode, port0_rmii_mac}),
    .sync_out(pins_s)
  );

  assign eee_pin_s = pins_s[3];
  assign rate_pin_s = pins_s[2];
  assign fx_s = pins_s[1];
  assign rmii_s = pins_s[0];

  // Register access only once defaults are in place
  assign access = psel && penable && !ready_q && (state_q == sdc_pkg::ST_READY);
  // Write lands at the edge where the master sees pready, never on a refused place
  assign wr_en = psel && penable && ready_q && pwrite && !err_q;

  // Pin level decoded through the shared polarity bit
  assign pin_100 = straps_q.p0 ? rate_pin_s : ~rate_pin_s;

  // Load sequence: settle, optional EEPROM, apply, ready
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= sdc_pkg::ST_SETTLE;
      settle_q <= 2'h0;
    end else begin
      unique case (state_q)
        sdc_pkg::ST_SETTLE: begin
          // Wait for the synchroniser to flush reset zeros
          settle_q <= settle_q + 2'h1;
          if (settle_q == sdc_pkg::SETTLE_CYCLES) begin
            state_q <= sdc_pkg::ST_EEPROM;
          end
        end
        sdc_pkg::ST_EEPROM: begin
          if (ee_done) begin
            state_q <= sdc_pkg::ST_APPLY;
          end
        end
        sdc_pkg::ST_APPLY: begin
          state_q <= sdc_pkg::ST_READY;
        end
        sdc_pkg::ST_READY: begin
          state_q <= sdc_pkg::ST_READY;
        end
        default: begin
          state_q <= sdc_pkg::ST_SETTLE; // Illegal one-hot code
        end
      endcase
    end
  end

  // Strap register: pin capture, EEPROM override, software write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      straps_q.eee <= 1'b0;
      straps_q.p0 <= sdc_pkg::P0_STRAP_RESET;
      ee_used_q <= 1'b0;
    end else if (state_q == sdc_pkg::ST_SETTLE && settle_q == sdc_pkg::SETTLE_CYCLES) begin
      // Pin level caught after release, not under reset
      straps_q.eee <= eee_pin_s;
    end else if (state_q == sdc_pkg::ST_EEPROM && ee_done && ee_valid) begin
      straps_q.eee <= ee_eee_bit;
      straps_q.p0 <= ee_port0_bit;
      ee_used_q <= 1'b1;
    end else if (wr_en && paddr == sdc_pkg::ADDR_STRAP) begin
      // One bit serves both speed and polarity
      straps_q.eee <= pwdata[sdc_pkg::STRAP_EEE_BIT];
      straps_q.p0 <= pwdata[sdc_pkg::STRAP_P0_BIT];
    end
  end

  // MAC and PHY EEE defaults; FX mode at apply loads EEE off, register writes can still set it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mac_eee_q <= 1'b0;
      phy_eee_q <= 3'h0;
    end else if (state_q == sdc_pkg::ST_APPLY) begin
      // No EEE negotiation result exists on fibre, so strap is ignored
      mac_eee_q <= straps_q.eee && !fx_s;
      phy_eee_q <= {3{straps_q.eee && !fx_s}};
    end else if (wr_en && paddr == sdc_pkg::ADDR_MAC_TX) begin
      mac_eee_q <= pwdata[0];
    end else if (wr_en && paddr == sdc_pkg::ADDR_PHY_EEE) begin
      phy_eee_q <= pwdata[2:0];
    end
  end

  // Partner ability default from the speed strap
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lp_q <= 4'h0;
    end else if (state_q == sdc_pkg::ST_APPLY) begin
      lp_q <= lp_from_speed(straps_q.p0);
    end else if (wr_en && paddr == sdc_pkg::ADDR_VPHY_LP) begin
      lp_q <= pwdata[3:0];
    end
  end

  // Port 0 speed resolution
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      spd_q <= 1'b0;
    end else if (state_q != sdc_pkg::ST_READY) begin
      spd_q <= 1'b0; // Held until defaults are applied
    end else if (rmii_s) begin
      spd_q <= pin_100;
    end else if (vphy_an_failed) begin
      spd_q <= straps_q.p0;
    end else begin
      spd_q <= vphy_an_spd100;
    end
  end

  // APB answer: ready one cycle into the access phase
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= sdc_pkg::ZERO_WORD;
    end else if (access) begin
      ready_q <= 1'b1;
      err_q <= !addr_hit(paddr);
      rdata_q <= sdc_pkg::ZERO_WORD;
      if (!pwrite) begin
        unique case (paddr)
          sdc_pkg::ADDR_STRAP: rdata_q <= {30'h0, straps_q.p0, straps_q.eee};
          sdc_pkg::ADDR_MAC_TX: rdata_q <= {31'h0, mac_eee_q};
          sdc_pkg::ADDR_PHY_EEE: rdata_q <= {29'h0, phy_eee_q};
          sdc_pkg::ADDR_VPHY_LP: rdata_q <= {28'h0, lp_q};
          sdc_pkg::ADDR_STATUS: rdata_q <= {27'h0, pin_100, fx_s, spd_q, ee_used_q, rdy_q};
          default: rdata_q <= sdc_pkg::ZERO_WORD; // Unmapped reads zero
        endcase
      end
    end else begin
      // Answer lasts one cycle
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end
  end

  // Ready flag in its own flop, so cfg_ready is no state decode
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= (state_q == sdc_pkg::ST_APPLY) || (state_q == sdc_pkg::ST_READY);
    end
  end

  // Outputs straight from flops
  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign mac_tx_eee_on = mac_eee_q;
  assign phy_eee_on = phy_eee_q[sdc_pkg::PHY_EEE_ON_BIT];
  assign port0_spd100 = spd_q;
  assign cfg_ready = rdy_q;
endmodule

// [sdc_pkg.sv]
// Package of constants and types for the strap default configuration block
package sdc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_STRAP = 8'h00; // Strap register
  localparam logic [7:0] ADDR_MAC_TX = 8'h04; // MAC transmit setup
  localparam logic [7:0] ADDR_PHY_EEE = 8'h08; // PHY B EEE bits
  localparam logic [7:0] ADDR_VPHY_LP = 8'h0C; // Virtual PHY partner ability
  localparam logic [7:0] ADDR_STATUS = 8'h10; // Load and speed status
  // Strap register fields
  localparam int STRAP_EEE_BIT = 0; // Port 2 EEE default
  localparam int STRAP_P0_BIT = 1; // Shared port 0 speed / polarity bit
  // PHY EEE register fields
  localparam int PHY_EEE_ON_BIT = 0; // PHY Mac_tx_eee_on
  localparam int PHY_CAP_BIT = 1; // 100BASE-TX EEE capability
  localparam int PHY_ADV_BIT = 2; // 100BASE-TX EEE advertisement
  // Partner ability fields
  localparam int LP_100FD_BIT = 3; // 100BASE-X full duplex
  localparam int LP_100HD_BIT = 2; // 100BASE-X half duplex
  localparam int LP_10FD_BIT = 1; // 10BASE-T full duplex
  localparam int LP_10HD_BIT = 0; // 10BASE-T half duplex
  // Status fields
  localparam int ST_DONE_BIT = 0; // Defaults applied
  localparam int ST_EE_BIT = 1; // EEPROM overrode the straps
  localparam int ST_SPD_BIT = 2; // Port 0 running at 100 Mbps
  localparam int ST_FX_BIT = 3; // PHY B in 100BASE-FX
  localparam int ST_PIN_BIT = 4; // Decoded rate pin says 100 Mbps
  // Reset values
  localparam logic P0_STRAP_RESET = 1'b1; // Speed and polarity default
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000; // Read data idle
  // Synchroniser width: eee pin, rate pin, fx mode, rmii mode
  localparam int SYNC_W = 4;
  // Cycles to wait after reset so synchronised pins are settled
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  // Captured strap values
  typedef struct packed {
    logic eee; // Port 2 EEE default
    logic p0; // Shared port 0 speed / polarity
  } sdc_straps_t;
  // Load sequence
  typedef enum logic [3:0] {
    ST_SETTLE = 4'h1,
    ST_EEPROM = 4'h2,
    ST_APPLY = 4'h4,
    ST_READY = 4'h8
  } sdc_state_t;
endpackage

// [sdc_sync.sv]
// Two-flop synchroniser for the strap and mode pins
`timescale 1ns/100ps
module sdc_sync (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic [sdc_pkg::SYNC_W-1:0] async_in, // Raw pin levels
  output logic [sdc_pkg::SYNC_W-1:0] sync_out // Synchronised levels
);
  logic [sdc_pkg::SYNC_W-1:0] meta_q; // First stage, read only by second

  // Two stages; the first is never looked at by logic
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// [sdc_sva.sv]
// Port assertions for the strap default loader
`timescale 1ns/100ps
module sdc_sva (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // Byte address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic phy_b_fx_mode, // Fibre mode
  input wire logic port0_rmii_mac, // RMII MAC mode
  input wire logic vphy_an_failed, // Negotiation failed
  input wire logic vphy_an_spd100, // Negotiated 100
  input wire logic mac_tx_eee_on, // MAC EEE
  input wire logic phy_eee_on, // PHY EEE
  input wire logic port0_spd100, // Port 0 speed
  input wire logic cfg_ready // Defaults applied
);
  // One clock domain, so one default for all
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ans_req: assert property (pready |-> $past(psel) && $past(penable) && cfg_ready)
    else $error("answer without request");
  a_ans_bound: assert property (psel && penable && !pready && cfg_ready |=> pready)
    else $error("access not answered");
  a_err_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
    else $error("error flag wrong");
  a_err_rd_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_ready_hold: assert property (cfg_ready |=> cfg_ready)
    else $error("ready dropped");
  a_spd_idle: assert property (!cfg_ready |-> !port0_spd100)
    else $error("speed before ready");
  a_fx_eee_off: assert property ($rose(cfg_ready) && phy_b_fx_mode |=> !mac_tx_eee_on && !phy_eee_on)
    else $error("eee on in fibre mode");
  // Negotiated speed wins outside RMII when negotiation worked
  a_spd_follow: assert property ((cfg_ready && !port0_rmii_mac && !vphy_an_failed && $stable(vphy_an_spd100))[*5]
    |-> port0_spd100 == vphy_an_spd100) else $error("speed not negotiated");
  c_loaded: cover property ($rose(cfg_ready));
  c_refused: cover property (pready && pslverr);
  c_held: cover property (psel && penable && !cfg_ready);
endmodule
bind sdc_top sdc_sva u_sva (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .phy_b_fx_mode(phy_b_fx_mode),
  .port0_rmii_mac(port0_rmii_mac),
  .vphy_an_failed(vphy_an_failed),
  .vphy_an_spd100(vphy_an_spd100),
  .mac_tx_eee_on(mac_tx_eee_on),
  .phy_eee_on(phy_eee_on),
  .port0_spd100(port0_spd100),
  .cfg_ready(cfg_ready)
);

// [sdc_ee_model.sv]
// EEPROM loader model feeding the strap loader
`timescale 1ns/100ps
module sdc_ee_model (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic [6:0] ee_cfg, // Valid, eee, p0, load delay
  output logic ee_done, // Load finished
  output logic ee_valid, // Contents present
  output logic ee_eee_bit, // EEE default bit
  output logic ee_port0_bit // Shared port 0 bit
);
  logic [3:0] cnt_q; // Load time elapsed
  // Count load time, then hold done as a level
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 4'h0;
    end else if (!ee_done) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign ee_done = resetn && (cnt_q == ee_cfg[3:0]); // Slow or prompt
  // Until done the bits are inverted, so early sampling shows
  assign ee_valid = ee_cfg[6] ~^ ee_done;
  assign ee_eee_bit = ee_cfg[5] ~^ ee_done;
  assign ee_port0_bit = ee_cfg[4] ~^ ee_done;
endmodule

// [tb.sv]
// Self-checking bench for the strap default loader
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'b0, resetn = 1'b0; // Clock and reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request
  logic [7:0] paddr = 8'h00; // Byte address
  logic [31:0] pwdata = 32'h0, prdata, rd; // Data
  logic pready, pslverr, er; // Answer
  logic eee_select_pin = 1'b0, port0_rate_indicator_pin = 1'b0; // Strap pins
  logic phy_b_fx_mode = 1'b0, port0_rmii_mac = 1'b0; // Mode pins
  logic vphy_an_failed = 1'b0, vphy_an_spd100 = 1'b0; // Negotiation
  logic ee_done, ee_valid, ee_eee_bit, ee_port0_bit; // EEPROM side
  logic [6:0] ee_cfg = 7'h00; // Model setup
  logic mac_tx_eee_on, phy_eee_on, port0_spd100, cfg_ready; // Outputs
  int fail_count = 0, comparisons = 0; // Tallies
  logic [12:0] row; // Current row
  // fx, ee valid, ee eee, ee p0, pin, rmii, rate, failed, an100 | p0, eee, mac, speed
  logic [12:0] rows [7] = '{13'h011F, 13'h112D, 13'h0981,
    13'h0E9E, 13'h0C76, 13'h04C9, 13'h1ECD};
  always #2 sys_clk = ~sys_clk; // 4 ns period
  sdc_top u_dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .eee_select_pin(eee_select_pin),
    .port0_rate_indicator_pin(port0_rate_indicator_pin),
    .phy_b_fx_mode(phy_b_fx_mode),
    .port0_rmii_mac(port0_rmii_mac),
    .ee_done(ee_done),
    .ee_valid(ee_valid),
    .ee_eee_bit(ee_eee_bit),
    .ee_port0_bit(ee_port0_bit),
    .vphy_an_failed(vphy_an_failed),
    .vphy_an_spd100(vphy_an_spd100),
    .mac_tx_eee_on(mac_tx_eee_on),
    .phy_eee_on(phy_eee_on),
    .port0_spd100(port0_spd100),
    .cfg_ready(cfg_ready)
  );
  sdc_ee_model u_ee (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ee_cfg(ee_cfg),
    .ee_done(ee_done),
    .ee_valid(ee_valid),
    .ee_eee_bit(ee_eee_bit),
    .ee_port0_bit(ee_port0_bit)
  );
  // Compare one value and tally
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One APB transfer; waits for pready, bounded since loads can stall it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h0000_0001, 32'(pready));
      final_report();
    end
  endtask
  // Reset with this row's pins and EEPROM, load delay grows per row
  task automatic rst(input int i);
    resetn <= 1'b0;
    {phy_b_fx_mode, ee_cfg[6:4], eee_select_pin, port0_rmii_mac, port0_rate_indicator_pin,
      vphy_an_failed, vphy_an_spd100} <= row[12:4];
    ee_cfg[3:0] <= 4'(2 * i + 1);
    repeat (8) @(posedge sys_clk);
    chk("reset outs", 32'h0, 32'({mac_tx_eee_on, phy_eee_on, port0_spd100, cfg_ready}));
    resetn <= 1'b1;
  endtask
  initial begin
    for (int i = 0; i < 7; i++) begin
      row = rows[i];
      rst(i);
      apb(1'b0, 8'h04, 32'h0); // Issued early, held until loaded
      chk("mac reg", 32'(row[1]), rd);
      chk("mac out", 32'(row[1]), 32'(mac_tx_eee_on));
      apb(1'b0, 8'h08, 32'h0);
      chk("phy reg", 32'({3{row[1]}}), rd);
      chk("phy out", 32'(row[1]), 32'(phy_eee_on));
      apb(1'b0, 8'h0C, 32'h0);
      chk("ability", row[3] ? 32'h0000_000C : 32'h0000_0003, rd);
      apb(1'b0, 8'h00, 32'h0);
      chk("strap", 32'(row[3:2]), rd);
      apb(1'b0, 8'h10, 32'h0);
      // Bit 4 is the rate pin seen through the polarity bit
      chk("status", 32'({row[3] ~^ row[6], row[12], row[0], row[11], 1'b1}), rd);
      chk("speed", 32'(row[0]), 32'(port0_spd100));
      $display("row %0d done", i);
    end
    // Awkward cases: rewrite, refused places, shared strap bit
    apb(1'b1, 8'h0C, 32'h0000_0005);
    apb(1'b1, 8'h20, 32'h0000_000F);
    chk("refused wr", 32'h0000_0001, 32'(er));
    apb(1'b0, 8'h0C, 32'h0);
    chk("ability rw", 32'h0000_0005, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("refused", 32'h0000_0001, 32'(er));
    chk("refused data", 32'h0, rd);
    // Polarity 0 with the last row's rate pin high means 10 Mbps
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b0, 8'h00, 32'h0);
    chk("strap rw", 32'h0000_0001, rd);
    chk("speed pol", 32'h0, 32'(port0_spd100));
    $display("register tests done");
    final_report();
  end
endmodule
